// [hw/ebr_pkg.sv]
/*
 * Shared constants, width codes, the port request struct and the
 * width decoding functions of the embedded block RAM.
 * Assumes it is compiled before every other file of the block.
 */
package ebr_pkg;

	localparam int EBR_DATA_BITS  = 4096; // Data bits in one block.
	localparam int EBR_TOTAL_BITS = 4608; // Data bits plus parity bits.
	localparam int EBR_ADDR_W     = 12;   // Deepest shape is 4K by 1.
	localparam int EBR_ROWS       = 128;  // Physical rows of the array.
	localparam int EBR_ROW_IDX_W  = 7;    // Bits that pick a row.
	localparam int EBR_ROW_W      = 36;   // Physical bits in a row.
	localparam int EBR_LANES      = 4;    // Byte lanes in a row.
	localparam int EBR_LANE_W     = 9;    // Eight data bits plus parity.
	localparam int EBR_DATA_LG_MAX = 5;   // Log2 of 32, widest data shape.
	localparam int EBR_PAR_LG_MAX  = 2;   // Log2 of 36 over 9.

	// Reset value of the byte enables: all lanes written.
	localparam logic [3:0] EBR_BE_RESET = 4'hF;

	// Port shapes; the parity shapes keep every ninth bit.
	typedef enum logic [3:0] {
		EBR_W1  = 4'h0,
		EBR_W2  = 4'h1,
		EBR_W4  = 4'h2,
		EBR_W8  = 4'h3,
		EBR_W9  = 4'h4,
		EBR_W16 = 4'h5,
		EBR_W18 = 4'h6,
		EBR_W32 = 4'h7,
		EBR_W36 = 4'h8
	} ebr_width_e;

	// One port's request as the fabric presents it on a clock edge.
	typedef struct packed {
		logic [EBR_ADDR_W-1:0] addr;       // Word address.
		logic [EBR_ROW_W-1:0]  wdata;      // Write data, low bits used.
		logic                  wr_en;      // Write this edge.
		logic [EBR_LANES-1:0]  byte_en;    // Byte lane mask.
		logic                  addr_stall; // Hold the last address.
	} ebr_port_s;

	// True for the shapes that keep the ninth bit of each byte.
	function automatic logic ebr_is_parity(input ebr_width_e w);
		ebr_is_parity = (w == EBR_W9) || (w == EBR_W18) || (w == EBR_W36);
	endfunction : ebr_is_parity

	// Log2 of the width, over 1 for data shapes and over 9 for parity.
	function automatic int ebr_width_lg(input ebr_width_e w);
		unique case (w)
			EBR_W1, EBR_W9:   ebr_width_lg = 0;
			EBR_W2, EBR_W18:  ebr_width_lg = 1;
			EBR_W4, EBR_W36:  ebr_width_lg = 2;
			EBR_W8:           ebr_width_lg = 3;
			EBR_W16:          ebr_width_lg = 4;
			EBR_W32:          ebr_width_lg = 5;
			default:          ebr_width_lg = 0;
		endcase
	endfunction : ebr_width_lg

endpackage : ebr_pkg

// [hw/ebr_port_map.sv]
/*
 * Maps one port's word address and shape onto a physical row, a
 * write mask and the read bits of that row.
 * Assumes the caller feeds back the row it selected through row_in.
 */
`timescale 1ns/1ns
module ebr_port_map import ebr_pkg::*; (
	input  ebr_width_e                 width,
	input  wire logic                  packed_mode,
	input  wire logic                  half_sel,
	input  wire logic [EBR_ADDR_W-1:0] addr,
	input  wire logic [EBR_ROW_W-1:0]  wdata,
	input  wire logic [EBR_LANES-1:0]  byte_en,
	input  wire logic [EBR_ROW_W-1:0]  row_in,
	output logic [EBR_ROW_IDX_W-1:0]   row_idx,
	output logic [EBR_ROW_W-1:0]       wmask,
	output logic [EBR_ROW_W-1:0]       wbits,
	output logic [EBR_ROW_W-1:0]       rdata
);

	ebr_width_e w_eff;                   // Shape after packed clamp.
	logic       par;                     // Parity shape in use.
	int         per;                     // Bits per word.
	int         base;                    // First bit of the word.
	logic [EBR_ADDR_W-1:0] row_full;     // Address shifted to rows.

	// Position of logical bit k of the word inside the physical row.
	// Data shapes skip the ninth bit of every lane.
	function automatic int phys_bit(input logic p, input int b,
		input int k);
		int l;
		l = b + k;
		phys_bit = p ? l : ((l / 8) * EBR_LANE_W + (l % 8));
	endfunction : phys_bit

	// Address decode; packed mode pins each port to its own half.
	always_comb begin
		int sl;
		int slot;
		sl = 0;
		slot = 0;
		w_eff = width;
		if (packed_mode && width == EBR_W32) begin
			w_eff = EBR_W16;
		end else if (packed_mode && width == EBR_W36) begin
			w_eff = EBR_W18;
		end
		par = ebr_is_parity(w_eff);
		per = par ? (EBR_LANE_W << ebr_width_lg(w_eff))
		          : (1 << ebr_width_lg(w_eff));
		sl = par ? (EBR_PAR_LG_MAX - ebr_width_lg(w_eff))
		         : (EBR_DATA_LG_MAX - ebr_width_lg(w_eff));
		row_full = addr >> sl;
		slot = int'(addr) & ((1 << sl) - 1);
		base = slot * per;
		row_idx = row_full[EBR_ROW_IDX_W-1:0];
		if (packed_mode) begin
			row_idx[EBR_ROW_IDX_W-1] = half_sel;
		end
	end

	// Scatter write bits and gather read bits; parity bits are plain
	// storage, so no checking happens here.
	always_comb begin
		int p;
		int ln;
		p = 0;
		ln = 0;
		wmask = '0;
		wbits = '0;
		rdata = '0;
		for (int k = 0; k < EBR_ROW_W; k++) begin
			if (k < per) begin
				p = phys_bit(par, base, k);
				ln = par ? (k / EBR_LANE_W) : (k / 8);
				// Narrow shapes use lane 0 as a second write enable.
				wmask[p] = (per <= EBR_LANE_W) ? byte_en[0]
				                               : byte_en[ln];
				wbits[p] = wdata[k];
				rdata[k] = row_in[p];
			end
		end
	end

endmodule : ebr_port_map

// [hw/ebr_block.sv]
/*
 * Embedded block RAM with two ports of independent shape, byte enables,
 * address stall, optional output registers and packed mode.
 * Assumes both ports are driven by fabric logic on sys_clk.
 */
// What this block does
// - Holds 4096 data plus 512 parity bits.
// - Shapes from 4K by 1 to 128 by 36.
// - Two ports read or write together.
// - Byte enables mask which bytes are written.
// - Contents preload from an image at start.
// - Each port has its own width.
// - Same-port read during write returns new data.
// - Other-port read during write returns old data.
// - Clock enable freezes all but reset and clears.
// - Input registers have no asynchronous clear.
// - Only power-up, output clear, chip clear reset.
// - Output clear zeroes output registers at once.
// - Parity bits stored as plain data.
// - Enable bits 1 to 3 govern upper bytes.
// - Address stall reloads the previous address.
// - Packed mode gives two half-size single ports.
`timescale 1ns/1ns
module ebr_block import ebr_pkg::*; #(
	parameter logic [EBR_TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
	input  wire logic                 sys_clk,
	input  wire logic                 srst,
	input  wire logic                 clk_en,
	input  wire logic                 chip_wide_clear_n,
	input  wire logic                 out_aclr,
	input  wire logic                 packed_mode,
	input  ebr_width_e                a_width,
	input  ebr_width_e                b_width,
	input  wire logic                 a_out_reg_en,
	input  wire logic                 b_out_reg_en,
	input  ebr_port_s                 a_req,
	input  ebr_port_s                 b_req,
	output logic [EBR_ROW_W-1:0]      a_rdata,
	output logic [EBR_ROW_W-1:0]      b_rdata
);

	// Array and per-port registers; index 0 is port A, 1 is port B.
	logic [EBR_ROW_W-1:0]     mem_q [EBR_ROWS];
	logic [EBR_ROW_W-1:0]     mem_d [EBR_ROWS];
	logic [EBR_ADDR_W-1:0]    addr_q [2];          // Address registers.
	logic [EBR_ADDR_W-1:0]    addr_d [2];
	logic [EBR_ROW_W-1:0]     raw_q [2];           // Array read stage.
	logic [EBR_ROW_W-1:0]     raw_d [2];
	logic [EBR_ROW_W-1:0]     out_q [2];           // Output registers.
	logic [EBR_ROW_W-1:0]     out_d [2];

	ebr_port_s                req [2];             // Requests by index.
	ebr_width_e               width [2];           // Shapes by index.
	logic [EBR_ADDR_W-1:0]    eff_addr [2];        // Address used now.
	logic [EBR_ROW_IDX_W-1:0] row_idx [2];         // Selected rows.
	logic [EBR_ROW_W-1:0]     wmask [2];           // Bits to write.
	logic [EBR_ROW_W-1:0]     wbits [2];           // Placed write data.
	logic [EBR_ROW_W-1:0]     own_row [2];         // Row as own port sees.
	logic [EBR_ROW_W-1:0]     rd_bits [2];         // Word read this edge.

	assign req[0] = a_req;
	assign req[1] = b_req;
	assign width[0] = a_width;
	assign width[1] = b_width;

	// Flow-through or pipelined read data per port.
	assign a_rdata = a_out_reg_en ? out_q[0] : raw_q[0];
	assign b_rdata = b_out_reg_en ? out_q[1] : raw_q[1];

	// Address selection and own-port view of the row; the own view
	// carries this edge's write so a same-port read returns new data,
	// while the other port reads the array as it stood.
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			eff_addr[p] = req[p].addr_stall ? addr_q[p]
			                                : req[p].addr;
			own_row[p] = mem_q[row_idx[p]];
			if (req[p].wr_en) begin
				own_row[p] = (mem_q[row_idx[p]] & ~wmask[p])
				           | (wbits[p] & wmask[p]);
			end
		end
	end

	// One address mapper per port, each with its own shape.
	for (genvar g = 0; g < 2; g++) begin : g_map
		ebr_port_map u_map (
			.width      (width[g]),
			.packed_mode(packed_mode),
			.half_sel   (g == 1),
			.addr       (eff_addr[g]),
			.wdata      (req[g].wdata),
			.byte_en    (req[g].byte_en),
			.row_in     (own_row[g]),
			.row_idx    (row_idx[g]),
			.wmask      (wmask[g]),
			.wbits      (wbits[g]),
			.rdata      (rd_bits[g])
		);
	end

	// Next state of array, address and read registers. Power-up loads
	// the image; the chip clear empties registers but keeps contents.
	// A low clock enable holds everything else, as a stopped clock would.
	always_comb begin
		mem_d = mem_q;
		addr_d = addr_q;
		raw_d = raw_q;
		if (srst) begin
			for (int r = 0; r < EBR_ROWS; r++) begin
				mem_d[r] = INIT_IMAGE[r*EBR_ROW_W +: EBR_ROW_W];
			end
			addr_d = '{default: '0};
			raw_d = '{default: '0};
		end else if (!chip_wide_clear_n) begin
			addr_d = '{default: '0};
			raw_d = '{default: '0};
		end else if (clk_en) begin
			// Both ports act in the same edge; on a shared row B's
			// bytes are applied last, so B wins where both write.
			for (int p = 0; p < 2; p++) begin
				addr_d[p] = eff_addr[p];
				raw_d[p] = rd_bits[p];
				if (req[p].wr_en) begin
					mem_d[row_idx[p]] = (mem_d[row_idx[p]] & ~wmask[p])
					                  | (wbits[p] & wmask[p]);
				end
			end
		end
	end

	// Array and input-side registers: synchronous only, no async clear.
	always_ff @(posedge sys_clk) begin
		mem_q <= mem_d;
		addr_q <= addr_d;
		raw_q <= raw_d;
	end

	// Output register next value: follows the read stage one edge later.
	always_comb begin
		out_d = out_q;
		if (srst || !chip_wide_clear_n) begin
			out_d = '{default: '0};
		end else if (clk_en) begin
			out_d = raw_q;
		end
	end

	// Output registers alone take the asynchronous clear; it acts
	// without a clock edge, even while the clock enable is low.
	always_ff @(posedge sys_clk or posedge out_aclr) begin
		if (out_aclr) begin
			out_q <= '{default: '0};
		end else begin
			out_q <= out_d;
		end
	end

	// Helpers for the checks below.
	logic [EBR_ROW_W-1:0] a_old_row;   // Port A row before the edge.
	logic                 same_row_ab; // Both ports on one row.
	logic [EBR_ROW_W-1:0] a_keep_mask; // Lanes port A must not touch.
	logic                 aclr_hit_q;  // Output clear since last edge.
	assign a_old_row = mem_q[row_idx[0]];
	assign same_row_ab = (row_idx[0] == row_idx[1]);
	assign a_keep_mask = {{EBR_LANE_W{~a_req.byte_en[3]}},
	                      {EBR_LANE_W{~a_req.byte_en[2]}},
	                      {EBR_LANE_W{~a_req.byte_en[1]}},
	                      {EBR_LANE_W{~a_req.byte_en[0]}}};

	// Remembers an output clear that came between two edges. A short
	// pulse is never sampled on an edge, yet it zeroes the output, so
	// the pipeline check must skip the edge that follows it.
	always_ff @(posedge sys_clk or posedge out_aclr) begin
		if (out_aclr) begin
			aclr_hit_q <= 1'b1;
		end else begin
			aclr_hit_q <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_same_port_new: assert property (
		clk_en && chip_wide_clear_n && a_req.wr_en && !a_req.addr_stall
		&& a_width == EBR_W36 && a_req.byte_en == EBR_BE_RESET
		&& !packed_mode
		|=> raw_q[0] == $past(a_req.wdata))
		else $error("same-port read did not return new data");

	a_mixed_port_old: assert property (
		clk_en && chip_wide_clear_n && a_req.wr_en && !b_req.wr_en
		&& same_row_ab && b_width == EBR_W36 && !packed_mode
		|=> raw_q[1] == $past(a_old_row))
		else $error("other-port read did not return old data");

	a_byte_mask_keep: assert property (
		clk_en && chip_wide_clear_n && a_req.wr_en && !b_req.wr_en
		&& a_width == EBR_W36 && !packed_mode
		|=> ((mem_q[$past(row_idx[0])] ^ $past(a_old_row))
		    & $past(a_keep_mask)) == '0)
		else $error("disabled bytes were overwritten");

	a_clk_en_hold: assert property (
		!clk_en && chip_wide_clear_n
		|=> $stable(raw_q[0]) && $stable(addr_q[0])
		    && $stable(raw_q[1]) && $stable(addr_q[1]))
		else $error("state changed while clock enable was low");

	a_out_aclr_zero: assert property (
		out_aclr |-> out_q[0] == '0 && out_q[1] == '0)
		else $error("output clear did not zero outputs");

	a_addr_stall_hold: assert property (
		clk_en && chip_wide_clear_n && a_req.addr_stall
		|=> addr_q[0] == $past(addr_q[0]))
		else $error("address changed during stall");

	a_pipe_out: assert property (
		clk_en && chip_wide_clear_n && !out_aclr
		##1 !out_aclr && !aclr_hit_q
		|-> out_q[0] == $past(raw_q[0]))
		else $error("output register did not follow read stage");

	a_chip_clear: assert property (
		!chip_wide_clear_n ##1 !out_aclr
		|-> raw_q[0] == '0 && out_q[1] == '0 && addr_q[1] == '0)
		else $error("chip-wide clear left registers set");

	a_packed_halves: assert property (
		packed_mode |-> !row_idx[0][EBR_ROW_IDX_W-1]
		             && row_idx[1][EBR_ROW_IDX_W-1])
		else $error("packed ports left their halves");

	c_dual_write: cover property (
		clk_en && a_req.wr_en && b_req.wr_en);
	c_mixed_rdw: cover property (
		clk_en && a_req.wr_en && !b_req.wr_en && same_row_ab);
	c_stall_run: cover property (
		a_req.addr_stall [*3]);
	c_aclr_hit: cover property (
		out_aclr && a_out_reg_en);

endmodule : ebr_block

// [dv/ebr_fabric_model.sv]
/*
 * Fabric-side user logic that presents port requests to the block RAM.
 * Assumes the bench calls put shortly after a rising edge of sys_clk.
 */
`timescale 1ns/1ns
module ebr_fabric_model import ebr_pkg::*; (
	input  wire logic sys_clk,
	output ebr_port_s a_req,
	output ebr_port_s b_req
);
	// Both ports start idle with all byte lanes enabled.
	initial begin
		a_req = '{addr: '0, wdata: '0, wr_en: 1'b0,
			byte_en: EBR_BE_RESET, addr_stall: 1'b0};
		b_req = a_req;
	end

	// Present one request; it stays until replaced, so it is held
	// steady across the capturing edge, which avoids setup races.
	// Ninth bits ride along as plain data; no parity is made here,
	// and any FIFO or shift control would sit in this model too.
	task automatic put(input int p, input logic [11:0] ad,
		input logic [35:0] d, input int w, input logic [3:0] be,
		input int st);
		ebr_port_s r;
		r = '{addr: ad, wdata: d, wr_en: (w != 0), byte_en: be,
			addr_stall: (st != 0)};
		if (p != 0) begin
			b_req = r;
		end else begin
			a_req = r;
		end
	endtask : put
endmodule : ebr_fabric_model

// [dv/ebr_block_tb.sv]
/*
 * Self-checking bench for the block RAM, driving both ports through
 * the fabric model. Assumes synchronous reset and flow-through default.
 */
`timescale 1ns/1ns
module ebr_block_tb import ebr_pkg::*;;
	localparam logic [35:0] INI = 36'h5A5A5A5A5; // Preload row value.
	localparam logic [35:0] DAT = 36'h987654321; // Written pattern.
	localparam logic [EBR_TOTAL_BITS-1:0] IMG = {128{INI}};
	logic        sys_clk = 1'b0;      // Bench clock, 50 ns period.
	logic        srst = 1'b1;         // Synchronous reset.
	logic        clk_en = 1'b1;       // Whole-block clock enable.
	logic        chip_wide_clear_n = 1'b1;
	logic        out_aclr = 1'b0;     // Output register clear.
	logic        packed_mode = 1'b0;  // Two half memories.
	ebr_width_e  a_width = EBR_W36;   // Port A shape.
	ebr_width_e  b_width = EBR_W36;   // Port B shape.
	logic        a_out_reg_en = 1'b0; // Port A pipelined output.
	logic        b_out_reg_en = 1'b0; // Port B pipelined output.
	ebr_port_s   a_req;
	ebr_port_s   b_req;
	logic [35:0] a_rdata;
	logic [35:0] b_rdata;
	int          num_errors = 0;
	int          check_count = 0;
	int          wd[9] = '{1, 2, 4, 8, 9, 16, 18, 32, 36};
	logic [35:0] m;

	// Free-running clock.
	always #25 sys_clk = ~sys_clk;

	ebr_fabric_model u_fab (.sys_clk(sys_clk), .a_req(a_req), .b_req(b_req));

	ebr_block #(.INIT_IMAGE(IMG)) u_dut (
		.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
		.chip_wide_clear_n(chip_wide_clear_n), .out_aclr(out_aclr),
		.packed_mode(packed_mode), .a_width(a_width), .b_width(b_width),
		.a_out_reg_en(a_out_reg_en), .b_out_reg_en(b_out_reg_en),
		.a_req(a_req), .b_req(b_req), .a_rdata(a_rdata), .b_rdata(b_rdata));

	// Let one edge pass; inputs then change 5 ns after it.
	task automatic step();
		@(posedge sys_clk);
		#5;
	endtask : step

	// Compare one read word; unknown bits never match.
	task automatic chk(input string n, input logic [35:0] e,
		input logic [35:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Squeeze out the ninth bit of every lane.
	function automatic logic [31:0] sq(input logic [35:0] r);
		for (int l = 0; l < 32; l++) begin
			sq[l] = r[(l / 8) * 9 + l % 8];
		end
	endfunction : sq

	// Lanes enabled in be take new data, the others keep old.
	function automatic logic [35:0] mix(input logic [35:0] o,
		input logic [35:0] n, input logic [3:0] be);
		for (int k = 0; k < 4; k++) begin
			mix[k*9 +: 9] = be[k] ? n[k*9 +: 9] : o[k*9 +: 9];
		end
	endfunction : mix

	// Print the counts and the verdict, then end the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	// Watchdog: the tests need well under 100 cycles.
	initial begin
		#20000;
		num_errors++;
		stop_test();
	end

	// Main sequence.
	initial begin
		repeat (10) @(posedge sys_clk);
		#5 srst = 1'b0;
		chk("a_rdata", 36'h0, a_rdata);
		u_fab.put(0, 12'h3, 36'h0, 0, 4'hF, 0);
		step();
		chk("a_rdata", INI, a_rdata);
		u_fab.put(0, 12'h5, DAT, 1, 4'h5, 0);
		step();
		chk("a_rdata", mix(INI, DAT, 4'h5), a_rdata);
		$display("preload and byte enable test done");
		u_fab.put(0, 12'h6, DAT, 1, 4'hF, 0);
		u_fab.put(1, 12'h6, 36'h0, 0, 4'hF, 0);
		step();
		chk("b_rdata", INI, b_rdata);
		step();
		chk("b_rdata", DAT, b_rdata);
		$display("mixed port test done");
		u_fab.put(0, 12'h7, DAT, 1, 4'hF, 0);
		step();
		for (int i = 0; i < 9; i++) begin
			b_width = ebr_width_e'(i);
			m = (36'h1 << wd[i]) - 36'h1;
			u_fab.put(1, (i inside {4, 6, 8}) ? 12'(252 / wd[i]) :
				12'(224 / wd[i]), 36'h0, 0, 4'hF, 0);
			step();
			chk("b_rdata", (i inside {4, 6, 8}) ? (DAT & m) :
				({4'h0, sq(DAT)} & m), b_rdata);
		end
		b_width = EBR_W36;
		$display("width test done");
		clk_en = 1'b0;
		u_fab.put(0, 12'h8, 36'h0, 1, 4'hF, 0);
		step();
		chk("a_rdata", DAT, a_rdata);
		clk_en = 1'b1;
		u_fab.put(0, 12'h8, 36'h0, 0, 4'hF, 0);
		step();
		chk("a_rdata", INI, a_rdata);
		u_fab.put(0, 12'h5, 36'h0, 0, 4'hF, 0);
		step();
		u_fab.put(0, 12'h3, 36'h0, 0, 4'hF, 1);
		step();
		chk("a_rdata", mix(INI, DAT, 4'h5), a_rdata);
		$display("enable and stall test done");
		a_out_reg_en = 1'b1;
		u_fab.put(0, 12'h7, 36'h0, 0, 4'hF, 0);
		step();
		step();
		chk("a_rdata", DAT, a_rdata);
		out_aclr = 1'b1;
		#1 chk("a_rdata", 36'h0, a_rdata);
		step();
		chk("a_rdata", 36'h0, a_rdata);
		out_aclr = 1'b0;
		a_out_reg_en = 1'b0;
		step();
		chip_wide_clear_n = 1'b0;
		step();
		chk("a_rdata", 36'h0, a_rdata);
		chip_wide_clear_n = 1'b1;
		step();
		chk("a_rdata", DAT, a_rdata);
		$display("output and clear test done");
		packed_mode = 1'b1;
		a_width = EBR_W18;
		b_width = EBR_W18;
		u_fab.put(0, 12'h0, 36'h000012345, 1, 4'hF, 0);
		u_fab.put(1, 12'h0, 36'h00003ABCD, 1, 4'hF, 0);
		step();
		u_fab.put(0, 12'h0, 36'h0, 0, 4'hF, 0);
		u_fab.put(1, 12'h0, 36'h0, 0, 4'hF, 0);
		step();
		chk("a_rdata", 36'h000012345, a_rdata);
		chk("b_rdata", 36'h00003ABCD, b_rdata);
		$display("packed test done");
		stop_test();
	end
endmodule : ebr_block_tb
